// ===== rtl/mdb_defines.vh
// constants for the database address decoder
// Notes on behaviour
// - units 1-60; slave steps per sixty
// - fc01 discrete = 128B + 16P + D
// - fc02 discrete = 7680P + 960B + 16(N-1) + D
// - fc03 register = 8B + P
// - fc04 register = 256 + 480B + 60P + N-1
// - controller writes start at 8B + P
// - unit writes start at 256+480B+60P+N-1
// - coil equals register; whole parameter only
// - over 123 or buffer full: exception 02
// - link addresses are zero based
// - four logical slaves, unit offsets per slave
// - controller discrete address is sixteen times register
// - alarms latch; clear after read and accept
// - coil 0x0000 off, any non-zero on
// - readback two's complement, clamped per variant
// - diagnostics function 08 supported
// - 16-bit params, 8 per block, 32 blocks
// - bad function or length: exception 01
// - illegal address: exception 02
`ifndef MDB_DEFINES_VH
`define MDB_DEFINES_VH

// function codes
`define MDB_FC_RD_CTRL_BITS   8'h01
`define MDB_FC_RD_UNIT_BITS   8'h02
`define MDB_FC_RD_CTRL_REGS   8'h03
`define MDB_FC_RD_UNIT_REGS   8'h04
`define MDB_FC_WR_COIL        8'h05
`define MDB_FC_WR_REG         8'h06
`define MDB_FC_DIAG           8'h08
`define MDB_FC_WR_COILS       8'h0f
`define MDB_FC_WR_REGS        8'h10

// exception codes
`define MDB_EXC_NONE          8'h00
`define MDB_EXC_FUNC          8'h01
`define MDB_EXC_ADDR          8'h02

// regions
`define MDB_REG_NONE          2'h0
`define MDB_REG_CTRL          2'h1
`define MDB_REG_UNIT          2'h2

// address arithmetic, 17 bits wide
`define MDB_K_BLK_BITS        17'h00080
`define MDB_K_PAR_BITS        17'h00010
`define MDB_K_CTRL_BITS_END   17'h01000
`define MDB_K_UP_BITS         17'h01e00
`define MDB_K_UB_BITS         17'h003c0
`define MDB_K_UNIT_BITS       17'h00010
`define MDB_K_UNIT_BITS_END   17'h0f000
`define MDB_K_PAR_PER_BLK     17'h00008
`define MDB_K_CTRL_REG_END    17'h00100
`define MDB_K_UNIT_BASE       17'h00100
`define MDB_K_UB_REGS         17'h001e0
`define MDB_K_UP_REGS         17'h0003c
`define MDB_K_UNIT_REG_END    17'h03d00
`define MDB_K_ONE             17'h00001

// limits and fixed locations
`define MDB_MAX_WR_QTY        16'h007b
`define MDB_UNITS_PER_SLAVE   8'h3c
`define MDB_UNIT_LAST         7'h3b
`define MDB_ACCEPT_ADDR       17'h00005
`define MDB_COIL_ON_WORD      16'h0001
`define MDB_COIL_OFF_WORD     16'h0000
`define MDB_MAX_GENERIC       16'h7fff
`define MDB_MAX_ALT           16'h0fff
`define MDB_ZERO_WORD         16'h0000

// database geometry
`define MDB_NUM_UNITS         60
`define MDB_MEM_DEPTH         256
`define MDB_MEM_AW            8
`define MDB_DW                16

`endif

// ===== rtl/mdb_rb_mem.v
// readback store for controller parameters, registered read
`timescale 1ns/1ps
`include "mdb_defines.vh"
module mdb_rb_mem (
    // clock
    input  wire                      core_clk,
    // write port
    input  wire                      wr_en,
    input  wire [`MDB_MEM_AW-1:0]    wr_addr,
    input  wire [`MDB_DW-1:0]        wr_data,
    // read port
    input  wire [`MDB_MEM_AW-1:0]    rd_addr,
    output reg  [`MDB_DW-1:0]        rd_data_q
);
    reg [`MDB_DW-1:0] mem [0:`MDB_MEM_DEPTH-1];

    // 32 blocks of 8 sixteen-bit parameters
    always @(posedge core_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_q <= mem[rd_addr];
    end
endmodule

// ===== rtl/mdb_decoder.v
// request decoder mapping function code and address onto the database
`timescale 1ns/1ps
`include "mdb_defines.vh"
module mdb_decoder (
    // clock and reset
    input  wire         core_clk,
    input  wire         rst_n,
    // request, one-cycle strobe
    input  wire         req_valid,
    input  wire [7:0]   req_func,
    input  wire [15:0]  req_addr,
    input  wire [15:0]  req_qty,
    input  wire [15:0]  req_data,
    input  wire         req_len_bad,
    input  wire [1:0]   req_slave,
    // configuration and write queue state
    input  wire         alt_variant,
    input  wire         wq_full,
    // field unit alarm sources, asynchronous
    input  wire [59:0]  alarm_src,
    // decoded answer
    output reg          resp_valid_q,
    output reg  [7:0]   resp_exc_q,
    output reg  [1:0]   resp_region_q,
    output reg  [4:0]   resp_blk_q,
    output reg  [2:0]   resp_par_q,
    output reg  [5:0]   resp_unit_q,
    output reg  [7:0]   resp_unit_abs_q,
    output reg  [3:0]   resp_bit_q,
    output reg          resp_write_q,
    output reg          resp_coil_on_q,
    output reg  [15:0]  resp_wdata_q,
    output wire [15:0]  resp_rdata,
    output reg          resp_diag_q,
    output reg          accept_q,
    // latched alarms per unit
    output reg  [59:0]  alarm_latched_q
);
    // unit register address split into block, parameter, unit
    function [13:0] unit_dec;
        input [16:0] x;
        reg   [16:0] o;
        reg   [16:0] b;
        reg   [16:0] r;
        reg   [16:0] p;
        reg   [16:0] u;
        begin
            o = x - `MDB_K_UNIT_BASE;
            b = o / `MDB_K_UB_REGS;
            r = o % `MDB_K_UB_REGS;
            p = r / `MDB_K_UP_REGS;
            u = (r % `MDB_K_UP_REGS) + `MDB_K_ONE;
            unit_dec = {b[4:0], p[2:0], u[5:0]};
        end
    endfunction

    // controller register address split into block, parameter
    function [7:0] ctrl_dec;
        input [16:0] x;
        reg   [16:0] b;
        reg   [16:0] p;
        begin
            b = x / `MDB_K_PAR_PER_BLK;
            p = x % `MDB_K_PAR_PER_BLK;
            ctrl_dec = {b[4:0], p[2:0]};
        end
    endfunction

    // readback value limited to the variant range
    function [15:0] clamp;
        input [15:0] v;
        input        alt;
        reg   [15:0] mx;
        begin
            mx = alt ? `MDB_MAX_ALT : `MDB_MAX_GENERIC;
            if (v[15]) begin
                clamp = `MDB_ZERO_WORD;
            end else if (v > mx) begin
                clamp = mx;
            end else begin
                clamp = v;
            end
        end
    endfunction

    // last unit index of a read, held inside one slave's sixty
    function [6:0] unit_cap;
        input [16:0] x;
        begin
            if (x > {10'h000, `MDB_UNIT_LAST}) begin
                unit_cap = `MDB_UNIT_LAST;
            end else begin
                unit_cap = x[6:0];
            end
        end
    endfunction

    // single writes ignore the quantity field
    function single_wr;
        input [7:0] f;
        begin
            single_wr = (f == `MDB_FC_WR_COIL) || (f == `MDB_FC_WR_REG);
        end
    endfunction

    // alarm source synchroniser
    reg  [59:0] alarm_s1_q;
    reg  [59:0] alarm_s2_q;
    reg  [59:0] seen_q;

    // decode results
    reg  [7:0]  exc_d;
    reg  [1:0]  region_d;
    reg  [4:0]  blk_d;
    reg  [2:0]  par_d;
    reg  [5:0]  unit_d;
    reg  [3:0]  bit_d;
    reg         write_d;
    reg         multi_d;
    reg         rd_unit_d;
    reg         diag_d;
    reg  [6:0]  lo_u_d;
    reg  [6:0]  hi_u_d;
    reg  [16:0] a;
    reg  [16:0] last;
    reg  [16:0] qty_eff;
    reg  [16:0] t;
    reg  [16:0] r;
    reg  [16:0] r2;
    reg  [13:0] ud;
    reg  [7:0]  cd;
    wire        coil_on;
    wire [15:0] wword;
    wire        mem_we;
    wire        accept_d;
    wire [7:0]  unit_abs;

    always @* begin
        exc_d     = `MDB_EXC_NONE;
        region_d  = `MDB_REG_NONE;
        blk_d     = 5'h00;
        par_d     = 3'h0;
        unit_d    = 6'h00;
        bit_d     = 4'h0;
        write_d   = 1'b0;
        multi_d   = 1'b0;
        rd_unit_d = 1'b0;
        diag_d    = 1'b0;
        lo_u_d    = 7'h00;
        hi_u_d    = 7'h00;
        t         = 17'h00000;
        r         = 17'h00000;
        r2        = 17'h00000;
        ud        = 14'h0000;
        cd        = 8'h00;
        // addresses on the link are taken as zero based
        a         = {1'b0, req_addr};
        if (single_wr(req_func)) begin
            qty_eff = `MDB_K_ONE;
        end else begin
            qty_eff = {1'b0, req_qty};
        end
        last = a + qty_eff - `MDB_K_ONE;
        case (req_func)
            `MDB_FC_RD_CTRL_BITS: begin
                // discrete = 16 x register address
                if (last < `MDB_K_CTRL_BITS_END) begin
                    region_d = `MDB_REG_CTRL;
                end
                t     = a / `MDB_K_BLK_BITS;
                blk_d = t[4:0];
                r     = a % `MDB_K_BLK_BITS;
                t     = r / `MDB_K_PAR_BITS;
                par_d = t[2:0];
                t     = a % `MDB_K_PAR_BITS;
                bit_d = t[3:0];
            end
            `MDB_FC_RD_UNIT_BITS: begin
                // blocks 0 to 7 only
                if (last < `MDB_K_UNIT_BITS_END) begin
                    region_d = `MDB_REG_UNIT;
                end
                rd_unit_d = 1'b1;
                t      = a / `MDB_K_UP_BITS;
                par_d  = t[2:0];
                r      = a % `MDB_K_UP_BITS;
                t      = r / `MDB_K_UB_BITS;
                blk_d  = t[4:0];
                r2     = r % `MDB_K_UB_BITS;
                t      = (r2 / `MDB_K_UNIT_BITS) + `MDB_K_ONE;
                unit_d = t[5:0];
                t      = r2 % `MDB_K_UNIT_BITS;
                bit_d  = t[3:0];
                t      = r2 / `MDB_K_UNIT_BITS;
                lo_u_d = t[6:0];
                t      = (r2 + qty_eff - `MDB_K_ONE) / `MDB_K_UNIT_BITS;
                hi_u_d = unit_cap(t);
            end
            `MDB_FC_RD_CTRL_REGS: begin
                if (last < `MDB_K_CTRL_REG_END) begin
                    region_d = `MDB_REG_CTRL;
                end
                cd    = ctrl_dec(a);
                blk_d = cd[7:3];
                par_d = cd[2:0];
            end
            `MDB_FC_RD_UNIT_REGS: begin
                if ((a >= `MDB_K_UNIT_BASE) && (last < `MDB_K_UNIT_REG_END)) begin
                    region_d = `MDB_REG_UNIT;
                end
                rd_unit_d = 1'b1;
                ud     = unit_dec(a);
                blk_d  = ud[13:9];
                par_d  = ud[8:6];
                unit_d = ud[5:0];
                lo_u_d = {1'b0, ud[5:0]} - 7'h01;
                t      = {11'h000, ud[5:0]} + qty_eff - 17'h00002;
                hi_u_d = unit_cap(t);
            end
            `MDB_FC_WR_COIL, `MDB_FC_WR_REG, `MDB_FC_WR_COILS, `MDB_FC_WR_REGS: begin
                // coils and registers share one location scheme
                write_d = 1'b1;
                multi_d = !single_wr(req_func);
                if (last < `MDB_K_CTRL_REG_END) begin
                    region_d = `MDB_REG_CTRL;
                    cd       = ctrl_dec(a);
                    blk_d    = cd[7:3];
                    par_d    = cd[2:0];
                end else if ((a >= `MDB_K_UNIT_BASE) && (last < `MDB_K_UNIT_REG_END)) begin
                    region_d = `MDB_REG_UNIT;
                    ud       = unit_dec(a);
                    blk_d    = ud[13:9];
                    par_d    = ud[8:6];
                    unit_d   = ud[5:0];
                end
            end
            `MDB_FC_DIAG: begin
                diag_d = 1'b1;
            end
            default: begin
                exc_d = `MDB_EXC_FUNC;
            end
        endcase
        if (req_len_bad) begin
            exc_d = `MDB_EXC_FUNC;
        end else if (exc_d == `MDB_EXC_NONE) begin
            if (multi_d && ((req_qty > `MDB_MAX_WR_QTY) || (req_qty == 16'h0000))) begin
                exc_d = `MDB_EXC_ADDR;
            end else if (write_d && wq_full) begin
                exc_d = `MDB_EXC_ADDR;
            end else if (!diag_d && (region_d == `MDB_REG_NONE)) begin
                exc_d = `MDB_EXC_ADDR;
            end
        end
    end

    // coil data: zero turns off, anything else on
    assign coil_on = (req_data != `MDB_ZERO_WORD);
    assign wword   = ((req_func == `MDB_FC_WR_COIL) || (req_func == `MDB_FC_WR_COILS)) ?
                     (coil_on ? `MDB_COIL_ON_WORD : `MDB_COIL_OFF_WORD) : req_data;

    assign mem_we  = req_valid && write_d && (exc_d == `MDB_EXC_NONE) &&
                     (region_d == `MDB_REG_CTRL);

    // accept write covering block 0 parameter 5
    assign accept_d = mem_we && (a <= `MDB_ACCEPT_ADDR) && (last >= `MDB_ACCEPT_ADDR);

    // absolute unit across the four logical slaves
    assign unit_abs = ({6'h00, req_slave} * `MDB_UNITS_PER_SLAVE) + {2'h0, unit_d};

    mdb_rb_mem u_rb_mem (
        .core_clk  (core_clk),
        .wr_en     (mem_we),
        .wr_addr   (a[`MDB_MEM_AW-1:0]),
        .wr_data   (clamp(wword, alt_variant)),
        .rd_addr   (a[`MDB_MEM_AW-1:0]),
        .rd_data_q (resp_rdata)
    );

    // answer registers
    always @(posedge core_clk) begin
        if (!rst_n) begin
            resp_valid_q    <= 1'b0;
            resp_exc_q      <= `MDB_EXC_NONE;
            resp_region_q   <= `MDB_REG_NONE;
            resp_blk_q      <= 5'h00;
            resp_par_q      <= 3'h0;
            resp_unit_q     <= 6'h00;
            resp_unit_abs_q <= 8'h00;
            resp_bit_q      <= 4'h0;
            resp_write_q    <= 1'b0;
            resp_coil_on_q  <= 1'b0;
            resp_wdata_q    <= `MDB_ZERO_WORD;
            resp_diag_q     <= 1'b0;
            accept_q        <= 1'b0;
        end else begin
            resp_valid_q <= req_valid;
            accept_q     <= req_valid && accept_d;
            if (req_valid) begin
                resp_exc_q      <= exc_d;
                resp_region_q   <= region_d;
                resp_blk_q      <= blk_d;
                resp_par_q      <= par_d;
                resp_unit_q     <= unit_d;
                resp_unit_abs_q <= unit_abs;
                resp_bit_q      <= bit_d;
                resp_write_q    <= write_d && (exc_d == `MDB_EXC_NONE);
                resp_coil_on_q  <= coil_on;
                resp_wdata_q    <= wword;
                resp_diag_q     <= diag_d;
            end
        end
    end

    // alarm latching, read tracking and accept
    integer i;
    always @(posedge core_clk) begin
        if (!rst_n) begin
            alarm_s1_q      <= 60'h0;
            alarm_s2_q      <= 60'h0;
            alarm_latched_q <= 60'h0;
            seen_q          <= 60'h0;
        end else begin
            alarm_s1_q <= alarm_src;
            alarm_s2_q <= alarm_s1_q;
            for (i = 0; i < `MDB_NUM_UNITS; i = i + 1) begin
                // a new source wins over any clear
                if (alarm_s2_q[i]) begin
                    alarm_latched_q[i] <= 1'b1;
                end else if (accept_d && req_valid && seen_q[i]) begin
                    alarm_latched_q[i] <= 1'b0;
                end
                if (req_valid && rd_unit_d && (exc_d == `MDB_EXC_NONE) &&
                    (i >= lo_u_d) && (i <= hi_u_d) && alarm_latched_q[i]) begin
                    seen_q[i] <= 1'b1;
                end else if (accept_d && req_valid) begin
                    seen_q[i] <= 1'b0;
                end
            end
        end
    end
endmodule

// ===== bench/mdb_decoder_assertions.sv
// assertion checker bound to the request decoder
`timescale 1ns/1ps
module mdb_decoder_chk (
    // clock and reset
    input wire        core_clk,
    input wire        rst_n,
    // request
    input wire        req_valid,
    input wire [7:0]  req_func,
    input wire [15:0] req_addr,
    input wire [15:0] req_qty,
    input wire [15:0] req_data,
    input wire        req_len_bad,
    input wire        wq_full,
    // answer
    input wire        resp_valid_q,
    input wire [7:0]  resp_exc_q,
    input wire [1:0]  resp_region_q,
    input wire [4:0]  resp_blk_q,
    input wire [2:0]  resp_par_q,
    input wire [3:0]  resp_bit_q,
    input wire        resp_write_q,
    input wire [15:0] resp_wdata_q,
    input wire        accept_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire ok = req_valid && !req_len_bad;
    wire one = ok && req_qty == 16'h0001;
    wire wr = ok && !wq_full;
    property p_answer;
        req_valid ##1 !req_valid |-> resp_valid_q ##1 !resp_valid_q;
    endproperty
    a_answer: assert property (p_answer) else $error("answer not one cycle");
    property p_len;
        req_valid && req_len_bad |=> resp_exc_q == 8'h01 && !resp_write_q;
    endproperty
    a_len: assert property (p_len) else $error("bad length taken");
    property p_func;
        ok && !(req_func inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h0f,
            8'h10}) |=> resp_exc_q == 8'h01;
    endproperty
    a_func: assert property (p_func) else $error("unknown function taken");
    property p_qty;
        ok && req_func inside {8'h0f, 8'h10} && (req_qty == 16'h0000 || req_qty > 16'h007b)
            |=> resp_exc_q == 8'h02 && !accept_q;
    endproperty
    a_qty: assert property (p_qty) else $error("write count not refused");
    property p_full;
        ok && wq_full && req_func inside {8'h05, 8'h06, 8'h0f, 8'h10}
            |=> resp_exc_q == 8'h02 && !resp_write_q;
    endproperty
    a_full: assert property (p_full) else $error("write taken while full");
    property p_fc01;
        one && req_func == 8'h01 && req_addr < 16'h1000 |=> resp_exc_q == 8'h00
            && resp_blk_q == $past(req_addr[11:7]) && resp_par_q == $past(req_addr[6:4])
            && resp_bit_q == $past(req_addr[3:0]);
    endproperty
    a_fc01: assert property (p_fc01) else $error("bit read decode wrong");
    property p_fc03;
        one && req_func == 8'h03 && req_addr < 16'h0100 |=> resp_region_q == 2'h1
            && resp_blk_q == $past(req_addr[7:3]) && resp_par_q == $past(req_addr[2:0]);
    endproperty
    a_fc03: assert property (p_fc03) else $error("register read decode wrong");
    property p_coil;
        wr && req_func == 8'h05 && req_addr < 16'h0100 |=> resp_write_q
            && resp_wdata_q == {15'h0000, $past(req_data) != 16'h0000};
    endproperty
    a_coil: assert property (p_coil) else $error("coil word wrong");
    property p_accept;
        wr && req_func == 8'h06 && req_addr == 16'h0005 |=> accept_q && resp_write_q;
    endproperty
    a_accept: assert property (p_accept) else $error("alarm accept missed");
endmodule

bind mdb_decoder mdb_decoder_chk i_chk (
    .core_clk, .rst_n, .req_valid, .req_func, .req_addr, .req_qty, .req_data,
    .req_len_bad, .wq_full, .resp_valid_q, .resp_exc_q, .resp_region_q, .resp_blk_q,
    .resp_par_q, .resp_bit_q, .resp_write_q, .resp_wdata_q, .accept_q
);

// ===== bench/mdb_host_model.sv
// host side request driver for the decoder
`timescale 1ns/1ps
module mdb_host_model (
    // clock
    input  wire        core_clk,
    // request
    output reg         req_valid,
    output reg  [7:0]  req_func,
    output reg  [15:0] req_addr,
    output reg  [15:0] req_qty,
    output reg  [15:0] req_data,
    output reg         req_len_bad,
    output reg  [1:0]  req_slave
);
    initial begin
        req_valid = 1'b0;
        {req_func, req_addr, req_qty, req_data, req_len_bad, req_slave} = '0;
    end
    // one request per cycle, entered at a falling edge
    task send(input [7:0] f, input [15:0] a, q, d, input bad, input [1:0] s);
        begin
            req_valid = 1'b1;
            req_func = f;
            req_addr = a;
            req_qty = q;
            req_data = d;
            req_len_bad = bad;
            req_slave = s;
            @(negedge core_clk);
        end
    endtask
    // idle cycles pace the writes; released fields turn over
    task rest(input int n);
        begin
            req_valid = 1'b0;
            {req_func, req_addr, req_data} = ~{req_func, req_addr, req_data};
            repeat (n) @(negedge core_clk);
        end
    endtask
endmodule

// ===== bench/tb_modbus_database_address_decoder.sv
// self-checking bench for the database address decoder
`timescale 1ns/1ps
module tb_modbus_database_address_decoder;
    typedef struct {
        logic [7:0]  exc, ua;
        logic [15:0] wd, rd;
        logic [1:0]  rg;
        logic [4:0]  b;
        logic [2:0]  p;
        logic [5:0]  u;
        logic [3:0]  bt;
        logic        wr, cw, cr, cb, dg, co;
    } mdb_exp_t;
    logic        core_clk, rst_n, alt_variant, wq_full, nxt_cr;
    logic [59:0] alarm_src;
    logic [15:0] seed, nxt_rd, ra;
    logic [7:0]  rf;
    logic [55:0] tbl [0:18];
    int          err_count, total_checks;
    mdb_exp_t    exp_q[$];
    mdb_exp_t    got;
    wire         req_valid, req_len_bad, resp_valid_q, resp_write_q, resp_coil_on_q;
    wire         resp_diag_q, accept_q;
    wire [7:0]   req_func, resp_exc_q, resp_unit_abs_q;
    wire [15:0]  req_addr, req_qty, req_data, resp_wdata_q, resp_rdata;
    wire [1:0]   req_slave, resp_region_q;
    wire [4:0]   resp_blk_q;
    wire [2:0]   resp_par_q;
    wire [5:0]   resp_unit_q;
    wire [3:0]   resp_bit_q;
    wire [59:0]  alarm_latched_q;

    mdb_host_model i_host (.core_clk, .req_valid, .req_func, .req_addr, .req_qty, .req_data,
        .req_len_bad, .req_slave);
    mdb_decoder i_dut (.core_clk, .rst_n, .req_valid, .req_func, .req_addr, .req_qty,
        .req_data, .req_len_bad, .req_slave, .alt_variant, .wq_full, .alarm_src,
        .resp_valid_q, .resp_exc_q, .resp_region_q, .resp_blk_q, .resp_par_q, .resp_unit_q,
        .resp_unit_abs_q, .resp_bit_q, .resp_write_q, .resp_coil_on_q, .resp_wdata_q,
        .resp_rdata, .resp_diag_q, .accept_q, .alarm_latched_q);

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input logic [15:0] g, x, input string m);
        total_checks++;
        if (g !== x) begin
            err_count++;
            $display("BAD %0t %s got %h want %h", $time, m, g, x);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // note the expected answer, then hand the request to the host
    task automatic req(input [7:0] f, input [15:0] a, q, d, input bad);
        mdb_exp_t e;
        int hi, o;
        logic ok, wrf;
        e = '{default: '0};
        wrf = f inside {8'h05, 8'h06, 8'h0f, 8'h10};
        hi = a + ((f == 8'h05 || f == 8'h06) ? 1 : q) - 1;
        o = a - 256;
        case (f)
            8'h01: ok = hi < 4096;
            8'h02: ok = hi < 61440;
            8'h03: ok = hi < 256;
            8'h04: ok = a >= 256 && hi < 15616;
            8'h08: ok = 1'b1;
            default: ok = hi < 256 || (a >= 256 && hi < 15616);
        endcase
        if (wrf && (wq_full || (f > 8'h06 && (q == 0 || q > 123))))
            ok = 1'b0;
        if (bad || !(f inside {[8'h01:8'h06], 8'h08, 8'h0f, 8'h10}))
            e.exc = 8'h01;
        else
            e.exc = ok ? 8'h00 : 8'h02;
        e.bt = 4'(a);
        if (e.exc != 8'h00 || f == 8'h08)
            e.rg = 2'h0;
        else if (f == 8'h01)
            {e.rg, e.b, e.p, e.u, e.bt} = {2'h1, 5'(a / 128), 3'(a / 16), 6'h0, 4'(a)};
        else if (f == 8'h02)
            {e.rg, e.b, e.p, e.u, e.bt} = {2'h2, 5'(a % 7680 / 960), 3'(a / 7680),
                6'(a % 960 / 16 + 1), 4'(a)};
        else if (a < 256)
            {e.rg, e.b, e.p, e.u} = {2'h1, 5'(a / 8), 3'(a), 6'h0};
        else
            {e.rg, e.b, e.p, e.u} = {2'h2, 5'(o / 480), 3'(o % 480 / 60), 6'(o % 60 + 1)};
        e.cb = f < 8'h03;
        e.wr = wrf && e.exc == 8'h00;
        e.cw = e.wr && f < 8'h07;
        e.wd = (f == 8'h05) ? {15'h0, d != 16'h0} : d;
        {e.dg, e.co, e.ua} = {f == 8'h08, d != 16'h0, 8'(60 * seed[1:0] + e.u)};
        {e.cr, e.rd} = {nxt_cr, nxt_rd};
        nxt_cr = 1'b0;
        exp_q.push_back(e);
        i_host.send(f, a, q, d, bad, seed[1:0]);
        seed = lfsr(seed);
    endtask
    // write a word then read it back through the readback store
    task rb(input alt, full, input [7:0] f, input [15:0] d, x);
        {alt_variant, wq_full} = {alt, full};
        req(f, 16'h0009, 16'h0002, d, 1'b0);
        wq_full = 1'b0;
        i_host.rest(1);
        {nxt_cr, nxt_rd} = {1'b1, x};
        req(8'h03, 16'h0009, 16'h0001, 16'h0000, 1'b0);
        i_host.rest(1);
    endtask
    task done(input string n);
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 20) begin
            @(posedge core_clk);
            k++;
        end
        if (exp_q.size() != 0) begin
            err_count++;
            $display("BAD %0t answers missing", $time);
            finish_test;
        end else begin
            $display("test %s done", n);
            @(negedge core_clk);
        end
    endtask

    always @(negedge core_clk) begin
        if (resp_valid_q === 1'b1) begin
            got = exp_q.pop_front();
            chk(resp_exc_q, got.exc, "exception");
            chk(resp_write_q, got.wr, "write");
            if (got.rg != 2'h0) chk({resp_region_q, resp_blk_q, resp_par_q, resp_unit_q},
                {got.rg, got.b, got.p, got.u}, "index");
            if (got.cb) chk(resp_bit_q, got.bt, "bit");
            if (got.cw) chk(resp_wdata_q, got.wd, "wdata");
            if (got.cr) chk(resp_rdata, got.rd, "readback");
            if (got.rg != 2'h0) chk(resp_unit_abs_q, got.ua, "slave unit");
            chk({resp_diag_q, resp_coil_on_q}, {got.dg, got.co}, "flags");
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        {rst_n, alt_variant, wq_full, nxt_cr, alarm_src, nxt_rd} = '0;
        {err_count, total_checks} = '0;
        seed = 16'h46eb;
        tbl = '{56'h01_0fff_0001_0000, 56'h01_0fff_0002_0000, 56'h02_efff_0001_0000,
            56'h02_0780_0010_0000, 56'h03_00ff_0001_0000, 56'h03_00ff_0002_0000,
            56'h04_0100_003c_0000, 56'h04_3cff_0001_0000, 56'h04_00ff_0001_0000,
            56'h05_0007_0001_ff00, 56'h05_0007_0001_0000, 56'h05_0007_0001_0003,
            56'h06_3cff_0001_1234, 56'h0f_0000_007b_0001, 56'h10_0000_007c_0001,
            56'h10_0000_0000_0001, 56'h11_0000_0001_0000, 56'h08_0000_0001_0000,
            56'h03_0000_0001_0000};
        repeat (7) @(negedge core_clk);
        rst_n = 1'b1;
        foreach (tbl[i]) req(tbl[i][55:48], tbl[i][47:32], tbl[i][31:16],
            tbl[i][15:0], i == 18);
        i_host.rest(2);
        done("codes");
        repeat (40) begin
            {wq_full, alt_variant} = seed[15:14];
            rf = 8'(seed % 6 + 1);
            ra = 16'(lfsr(seed) % (rf == 8'h01 ? 4096 : rf == 8'h02 ? 61440 :
                rf == 8'h03 ? 256 : 15616));
            req(rf, ra, {12'h000, seed[11:8]} + 16'h0001, seed, seed[13] & seed[12]);
        end
        wq_full = 1'b0;
        i_host.rest(1);
        done("random");
        rb(1'b0, 1'b0, 8'h06, 16'h1234, 16'h1234);
        rb(1'b0, 1'b0, 8'h06, 16'h8000, 16'h0000);
        rb(1'b1, 1'b0, 8'h06, 16'h1234, 16'h0fff);
        rb(1'b1, 1'b1, 8'h06, 16'h0055, 16'h0fff);
        rb(1'b0, 1'b0, 8'h10, 16'h0abc, 16'h0abc);
        done("readback");
        alarm_src[2] = 1'b1;
        i_host.rest(5);
        alarm_src[2] = 1'b0;
        i_host.rest(5);
        chk(alarm_latched_q[2], 1'b1, "latch");
        req(8'h06, 16'h0005, 16'h0001, 16'h0001, 1'b0);
        i_host.rest(3);
        chk(alarm_latched_q[2], 1'b1, "unread");
        req(8'h04, 16'h0102, 16'h0001, 16'h0000, 1'b0);
        req(8'h06, 16'h0005, 16'h0001, 16'h0001, 1'b0);
        i_host.rest(3);
        chk(alarm_latched_q[2], 1'b0, "cleared");
        done("alarm");
        finish_test;
    end
endmodule
